/* File: ascf_map.svh */
`ifndef ASCF_MAP_SVH
`define ASCF_MAP_SVH
// Register byte offsets
`define ASCF_CTRL_OFF    12'h000
`define ASCF_DIV_OFF     12'h004
`define ASCF_TXDATA_OFF  12'h008
`define ASCF_RXDATA_OFF  12'h00C
`define ASCF_STATUS_OFF  12'h010
`define ASCF_IRQ_OFF     12'h014
`define ASCF_MASK_OFF    12'h018
// Control field positions
`define ASCF_CTRL_EIGHT  0
`define ASCF_CTRL_PAR_LO 1
`define ASCF_CTRL_PAR_HI 3
`define ASCF_CTRL_STOP2  4
`define ASCF_CTRL_TXEN   5
`define ASCF_CTRL_RXEN   6
// Reset values
`define ASCF_CTRL_RST    32'h00000061
`define ASCF_DIV_RST     16'h000D
// Event bits
`define ASCF_EV_TXDONE   0
`define ASCF_EV_RXDONE   1
`define ASCF_EV_PARERR   2
`define ASCF_EV_FRMERR   3
`define ASCF_EV_OVERRUN  4
// Oversampling ticks per bit
`define ASCF_OVS         16
`endif

/* File: ascf_pkg.sv */
package ascf_pkg;
  // Parity modes
  typedef enum logic [2:0] {
    ASCF_PAR_NONE  = 3'h0,
    ASCF_PAR_EVEN  = 3'h1,
    ASCF_PAR_ODD   = 3'h2,
    ASCF_PAR_SPACE = 3'h3,
    ASCF_PAR_MARK  = 3'h4
  } ascf_par_t;
  // Serial engine states, one-hot
  typedef enum logic [4:0] {
    ASCF_IDLE  = 5'h01,
    ASCF_START = 5'h02,
    ASCF_DATA  = 5'h04,
    ASCF_PAR   = 5'h08,
    ASCF_STOP  = 5'h10
  } ascf_state_t;
endpackage

/* File: ascf_tick_if.sv */
interface ascf_tick_if;
  logic        tick;
  logic [15:0] divisor;
  modport gen (input divisor, output tick);
  modport use_ (output divisor, input tick);
endinterface

/* File: ascf_tick_gen.sv */
module ascf_tick_gen
  import ascf_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Timebase
  ascf_tick_if.gen  tb
);
  logic [15:0] count;
  wire         wrap = (count == 16'h0000);

  // Oversample tick: one pulse every divisor+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else begin
      count <= wrap ? tb.divisor : count - 16'h0001;
    end
  end

  assign tb.tick = wrap;
endmodule

/* File: ascf_framer.sv */
// Functional notes
// - Data bits go out and come in least significant bit first.
// - Transmit line rests at logic 1 when no character is sent.
// - Each character starts with exactly one start bit at logic 0.
// - Each character ends with one or two stop bits at logic 1.
// - Falling edge of idle line starts receive timing of a character.
// - Idle gaps of any length between characters are allowed.
// - Character length is 7 or 8 data bits; 7 sends low seven.
// - Optional parity bit sits between last data bit and stop bit.
// - No-parity mode sends and checks no parity bit.
// - Even parity bit is 1 when data holds an odd number of ones.
// - Odd parity makes data plus parity ones count odd.
// - Space parity always sends parity bit as 0.
// - Mark parity always sends parity bit as 1.
// - One line state per bit, so bit rate equals baud rate.
//
// Added by the designer: the address map and the APB slave port.
`include "ascf_map.svh"
module ascf_framer
  import ascf_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rx_line,
  output logic             tx_line,
  // Interrupt
  output logic             irq
);
  localparam int OVS = `ASCF_OVS;
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID  = 4'(OVS / 2 - 1);

  ascf_tick_if tb ();
  ascf_tick_gen u_tick (.pclk(pclk), .presetn(presetn), .tb(tb));

  // Registers
  logic [6:0]  ctrl;
  logic [15:0] divisor;
  logic [4:0]  irq_stat;
  logic [4:0]  irq_mask;
  logic [7:0]  tx_hold;
  logic        tx_full;
  logic [7:0]  rx_hold;
  logic        rx_full;
  logic        tx_busy;
  logic        rx_busy;

  // Control decode
  wire         eight    = ctrl[`ASCF_CTRL_EIGHT];
  wire         stop2    = ctrl[`ASCF_CTRL_STOP2];
  wire         tx_en    = ctrl[`ASCF_CTRL_TXEN];
  wire         rx_en    = ctrl[`ASCF_CTRL_RXEN];
  wire [2:0]   par_raw  = ctrl[`ASCF_CTRL_PAR_HI:`ASCF_CTRL_PAR_LO];
  wire         par_on   = (par_raw != ASCF_PAR_NONE) && (par_raw <= ASCF_PAR_MARK);
  wire [3:0]   last_bit = eight ? 4'h7 : 4'h6;
  assign tb.divisor = divisor;

  // APB decode; no wait states, unmapped addresses read zero and error
  wire         acc      = psel && penable;
  wire         wr       = acc && pwrite;
  wire         rd       = acc && !pwrite;
  wire         hit_ctrl = (paddr == `ASCF_CTRL_OFF);
  wire         hit_div  = (paddr == `ASCF_DIV_OFF);
  wire         hit_tx   = (paddr == `ASCF_TXDATA_OFF);
  wire         hit_rx   = (paddr == `ASCF_RXDATA_OFF);
  wire         hit_st   = (paddr == `ASCF_STATUS_OFF);
  wire         hit_irq  = (paddr == `ASCF_IRQ_OFF);
  wire         hit_msk  = (paddr == `ASCF_MASK_OFF);
  wire         mapped   = hit_ctrl | hit_div | hit_tx | hit_rx | hit_st | hit_irq | hit_msk;
  wire [31:0]  status   = {26'h0, rx_full, tx_full, 4'h0} | {30'h0, rx_busy, tx_busy};
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Read mux; write-only and unmapped words read zero
  always_comb begin
    prdata = 32'h00000000;
    if (rd) begin
      unique case (1'b1)
        hit_ctrl: prdata = {25'h0, ctrl};
        hit_div:  prdata = {16'h0, divisor};
        hit_rx:   prdata = {24'h0, rx_hold};
        hit_st:   prdata = status;
        hit_irq:  prdata = {27'h0, irq_stat};
        hit_msk:  prdata = {27'h0, irq_mask};
        default:  prdata = 32'h00000000;
      endcase
    end
  end

  // Transmitter
  ascf_state_t tx_state;
  logic [3:0]  tx_ovs;
  logic [3:0]  tx_idx;
  logic [7:0]  tx_shift;
  logic        tx_par;
  logic        tx_stop_n;
  assign tx_busy = (tx_state != ASCF_IDLE);
  wire         tx_bit_end = tb.tick && (tx_ovs == OVS_LAST);
  wire [7:0]   tx_data  = eight ? tx_hold : {1'b0, tx_hold[6:0]};
  wire         tx_ones  = ^tx_data;
  logic        par_gen;
  // Parity to send; codes 5 to 7 act as no parity
  always_comb begin
    unique case (par_raw)
      ASCF_PAR_EVEN:  par_gen = tx_ones;
      ASCF_PAR_ODD:   par_gen = ~tx_ones;
      ASCF_PAR_SPACE: par_gen = 1'b0;
      ASCF_PAR_MARK:  par_gen = 1'b1;
      default:        par_gen = 1'b1;
    endcase
  end
  // Load only on a tick so the start bit is a full bit long
  wire         tx_load  = (tx_state == ASCF_IDLE) && tx_full && tx_en && tb.tick;
  wire         tx_done  = (tx_state == ASCF_STOP) && tx_bit_end && !tx_stop_n;

  // Serial state machine; idle gaps last as long as the holding slot is empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state  <= ASCF_IDLE;
      tx_ovs    <= 4'h0;
      tx_idx    <= 4'h0;
      tx_shift  <= 8'h00;
      tx_par    <= 1'b0;
      tx_stop_n <= 1'b0;
      tx_line   <= 1'b1;
    end else begin
      if (tb.tick) begin
        tx_ovs <= (tx_state == ASCF_IDLE) ? 4'h0 : tx_ovs + 4'h1;
      end
      unique case (tx_state)
        ASCF_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load) begin
            tx_shift <= tx_data;
            tx_par   <= par_gen;
            tx_idx   <= 4'h0;
            tx_line  <= 1'b0;
            tx_state <= ASCF_START;
          end
        end
        ASCF_START: if (tx_bit_end) begin
          tx_line  <= tx_shift[0];
          tx_shift <= {1'b0, tx_shift[7:1]};
          tx_state <= ASCF_DATA;
        end
        ASCF_DATA: if (tx_bit_end) begin
          if (tx_idx == last_bit) begin
            tx_line   <= par_on ? tx_par : 1'b1;
            tx_stop_n <= stop2;
            tx_state  <= par_on ? ASCF_PAR : ASCF_STOP;
          end else begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_idx   <= tx_idx + 4'h1;
          end
        end
        ASCF_PAR: if (tx_bit_end) begin
          tx_line  <= 1'b1;
          tx_state <= ASCF_STOP;
        end
        ASCF_STOP: if (tx_bit_end) begin
          if (tx_stop_n) begin
            tx_stop_n <= 1'b0;
          end else begin
            tx_state <= ASCF_IDLE;
          end
        end
        default: tx_state <= ASCF_IDLE;
      endcase
    end
  end

  // Receiver
  ascf_state_t rx_state;
  logic [3:0]  rx_ovs;
  logic [3:0]  rx_idx;
  logic [7:0]  rx_shift;
  logic        rx_prev;
  assign rx_busy = (rx_state != ASCF_IDLE);
  wire         rx_mid   = tb.tick && (rx_ovs == OVS_MID);
  wire         rx_fall  = rx_prev && !rx_line;
  wire [7:0]   rx_data  = eight ? rx_shift : {1'b0, rx_shift[7:1]};
  logic        par_exp;
  // Parity the received character should carry
  always_comb begin
    unique case (par_raw)
      ASCF_PAR_EVEN:  par_exp = ^rx_data;
      ASCF_PAR_ODD:   par_exp = ~^rx_data;
      ASCF_PAR_SPACE: par_exp = 1'b0;
      default:        par_exp = 1'b1;
    endcase
  end
  logic        ev_par;
  logic        ev_frm;
  logic        ev_rx;

  // Edge hunt, then centre sampling; character framed from its own edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= ASCF_IDLE;
      rx_ovs   <= 4'h0;
      rx_idx   <= 4'h0;
      rx_shift <= 8'h00;
      rx_prev  <= 1'b1;
      ev_par   <= 1'b0;
      ev_frm   <= 1'b0;
      ev_rx    <= 1'b0;
    end else begin
      rx_prev <= rx_line;
      ev_par  <= 1'b0;
      ev_frm  <= 1'b0;
      ev_rx   <= 1'b0;
      if (tb.tick) begin
        rx_ovs <= rx_ovs + 4'h1;
      end
      unique case (rx_state)
        ASCF_IDLE: if (rx_fall && rx_en) begin
          rx_ovs   <= 4'h0;
          rx_idx   <= 4'h0;
          rx_state <= ASCF_START;
        end
        ASCF_START: if (rx_mid) begin
          rx_state <= rx_line ? ASCF_IDLE : ASCF_DATA;
        end
        ASCF_DATA: if (rx_mid) begin
          rx_shift <= {rx_line, rx_shift[7:1]};
          rx_idx   <= rx_idx + 4'h1;
          if (rx_idx == last_bit) begin
            rx_state <= par_on ? ASCF_PAR : ASCF_STOP;
          end
        end
        ASCF_PAR: if (rx_mid) begin
          ev_par   <= (rx_line != par_exp);
          rx_state <= ASCF_STOP;
        end
        ASCF_STOP: if (rx_mid) begin
          ev_frm   <= !rx_line;
          ev_rx    <= 1'b1;
          rx_state <= ASCF_IDLE;
        end
        default: rx_state <= ASCF_IDLE;
      endcase
    end
  end

  // Holding registers; a new character beats a same-cycle read
  wire ev_ovr = ev_rx && rx_full && !(rd && hit_rx);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (wr && hit_tx && !tx_full) begin
        tx_hold <= pwdata[7:0];
      end
      tx_full <= (tx_full && !tx_load) || (wr && hit_tx);
      if (ev_rx) begin
        rx_hold <= rx_data;
      end
      rx_full <= ev_rx || (rx_full && !(rd && hit_rx));
    end
  end

  // Config registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= 7'(`ASCF_CTRL_RST);
      divisor  <= `ASCF_DIV_RST;
      irq_mask <= 5'h00;
    end else begin
      if (wr && hit_ctrl) ctrl <= pwdata[6:0];
      if (wr && hit_div) divisor <= pwdata[15:0];
      if (wr && hit_msk) irq_mask <= pwdata[4:0];
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  wire [4:0] ev_set = {ev_ovr, ev_frm, ev_par, ev_rx, tx_done};
  wire [4:0] ev_clr = (wr && hit_irq) ? pwdata[4:0] : 5'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 5'h00;
    end else begin
      irq_stat <= ev_set | (irq_stat & ~ev_clr);
    end
  end

  // Level output, high while an unmasked event is pending
  assign irq = |(irq_stat & irq_mask);
endmodule

/* File: ascf_framer_properties.sv */
`include "ascf_map.svh"
module ascf_framer_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial line and interrupt
  input wire logic        rx_line,
  input wire logic        tx_line,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase decode
  wire acc = psel && penable;
  wire mwr = acc && pwrite && paddr == `ASCF_MASK_OFF;
  wire iwr = acc && pwrite && paddr == `ASCF_IRQ_OFF;
  pready_high_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("unmapped not refused");
  mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 12'h018 |-> !pslverr)
    else $error("mapped refused");
  rdata_quiet_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  start_width_a: assert property ($fell(tx_line) |-> !tx_line [*8] ##1 !tx_line [*8])
    else $error("start bit short");
  // Minimum bit time is 16 cycles at the smallest divisor
  bit_hold_a: assert property ($changed(tx_line) |=> $stable(tx_line) [*8] ##1 $stable(tx_line) [*7])
    else $error("line bit short");
  irq_fall_a: assert property ($fell(irq) |-> $past(mwr || iwr)) else $error("irq fell unprompted");
  mask_off_a: assert property (mwr && pwdata[4:0] == 5'h00 |=> !irq) else $error("irq despite mask");
endmodule
bind ascf_framer ascf_framer_properties props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));

/* File: ascf_remote.sv */
module ascf_remote #(
  parameter int BIT_CYC = 16
) (
  // Clock reference
  input wire logic pclk,
  // Serial line
  input wire logic tx_line,
  output logic     rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cap;
  int          n_frames = 0;
  initial rx_line = 1'b1;
  // Twelve mid-bit samples; trailing ones show the idle line
  always begin
    @(negedge tx_line);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      cap[i] = tx_line;
      repeat (BIT_CYC) @(posedge pclk);
    end
    n_frames++;
  end
  // Trailing ones leave the line at mark between frames
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      rx_line <= f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask
  // Low pulse shorter than half a bit, then a bit of mark
  task automatic glitch(input int len);
    rx_line <= 1'b0;
    repeat (len) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
endmodule

/* File: tb.sv */
`include "ascf_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb
  import ascf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  logic        pready, pslverr, rx_line, tx_line, irq, err;
  int          num_errors = 0, checks_done = 0;
  // 25 MHz
  always #20 pclk = ~pclk;
  ascf_framer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
  ascf_remote #(.BIT_CYC(16)) partner_u (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_line));
  // One APB transfer, then an idle cycle so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
    if (pready !== 1'b1) num_errors++;
    rd_val = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd_val & m)
  endtask
  // Wait until the partner has seen k frames; running out is a mismatch
  task automatic wait_frame(input int k);
    int n;
    n = 0;
    while (partner_u.n_frames < k && n++ < 2000) @(posedge pclk);
    if (partner_u.n_frames < k) num_errors++;
  endtask
  // Expected line bits, start first, padded with idle ones
  function automatic logic [11:0] frame_of(input logic [7:0] d, input logic e8, input ascf_par_t pm);
    logic [11:0] f;
    int          p;
    logic        pb;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) if (i < 7 || e8) f[i + 1] = d[i];
    p = e8 ? 9 : 8;
    pb = e8 ? ^d : ^d[6:0];
    case (pm)
      ASCF_PAR_EVEN:  f[p] = pb;
      ASCF_PAR_ODD:   f[p] = ~pb;
      ASCF_PAR_SPACE: f[p] = 1'b0;
      default:        f[p] = 1'b1;
    endcase
    return f;
  endfunction
  // Receive one frame, check events, masking, clearing and data
  task automatic rx_char(input logic [11:0] f, input logic [31:0] dx, input logic [4:0] ev);
    int n;
    n = 0;
    partner_u.send(f);
    while (irq !== 1'b1 && n++ < 400) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    rdc(`ASCF_IRQ_OFF, 32'h1F, 32'(ev), "events");
    apb(1'b1, `ASCF_MASK_OFF, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `ASCF_IRQ_OFF, 32'h1F);
    apb(1'b1, `ASCF_MASK_OFF, 32'h2);
    `CHK("irq cleared", 1'b0, irq)
    rdc(`ASCF_RXDATA_OFF, 32'hFF, dx, "rx data");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    logic [7:0]  d;
    logic        e8;
    ascf_par_t   pm;
    logic [11:0] f;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`ASCF_CTRL_OFF, 32'hFFFFFFFF, `ASCF_CTRL_RST, "ctrl reset");
    rdc(`ASCF_DIV_OFF, 32'hFFFF, 32'(`ASCF_DIV_RST), "div reset");
    rdc(`ASCF_MASK_OFF, 32'h1F, 32'h0, "mask reset");
    rdc(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped read");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, `ASCF_DIV_OFF, 32'h0);
    apb(1'b1, `ASCF_MASK_OFF, 32'h2);
    for (int i = 0; i < 10; i++) begin
      d = 8'hC3 ^ 8'(i * 29);
      e8 = (i < 5);
      pm = ascf_par_t'(3'(i % 5));
      f = frame_of(d, e8, pm);
      apb(1'b1, `ASCF_CTRL_OFF, {25'h0, 2'b11, i[0], pm, e8});
      apb(1'b1, `ASCF_TXDATA_OFF, {24'h0, d});
      wait_frame(i + 1);
      `CHK("tx frame", f, partner_u.cap)
      rx_char(f, e8 ? {24'h0, d} : {25'h0, d[6:0]}, 5'h03);
    end
    apb(1'b1, `ASCF_CTRL_OFF, {25'h0, 2'b11, 1'b0, ASCF_PAR_EVEN, 1'b1});
    f = frame_of(8'h5A, 1'b1, ASCF_PAR_EVEN);
    f[9] = ~f[9];
    rx_char(f, 32'h5A, 5'h06);
    apb(1'b1, `ASCF_CTRL_OFF, {25'h0, 2'b11, 1'b0, ASCF_PAR_NONE, 1'b1});
    f = frame_of(8'h5A, 1'b1, ASCF_PAR_NONE);
    f[9] = 1'b0;
    rx_char(f, 32'h5A, 5'h0A);
    // Short low pulse must not start a character
    partner_u.glitch(4);
    rdc(`ASCF_STATUS_OFF, 32'h33, 32'h0, "false start");
    rdc(`ASCF_IRQ_OFF, 32'h1F, 32'h0, "no false char");
    // Held character kept while the transmitter is off; second write refused
    apb(1'b1, `ASCF_CTRL_OFF, 32'h41);
    apb(1'b1, `ASCF_TXDATA_OFF, 32'h3C);
    apb(1'b1, `ASCF_TXDATA_OFF, 32'h99);
    rdc(`ASCF_STATUS_OFF, 32'h33, 32'h10, "tx held");
    apb(1'b1, `ASCF_CTRL_OFF, 32'h61);
    wait_frame(11);
    `CHK("held frame", frame_of(8'h3C, 1'b1, ASCF_PAR_NONE), partner_u.cap)
    // Two characters left unread: overrun, newest kept
    partner_u.send(frame_of(8'h11, 1'b1, ASCF_PAR_NONE));
    partner_u.send(frame_of(8'h22, 1'b1, ASCF_PAR_NONE));
    rdc(`ASCF_STATUS_OFF, 32'h33, 32'h20, "rx full");
    rdc(`ASCF_IRQ_OFF, 32'h1F, 32'h13, "overrun");
    rdc(`ASCF_RXDATA_OFF, 32'hFF, 32'h22, "newest char");
    complete_run();
  end
endmodule
